/* hdl/tcc_timer_ctrl.sv */
/*
  Control logic of the cascadable 8-bit timer unit 3: APB register access,
  run/stop with counter clear, source clock selection from a prescaler,
  the low clock or the count pin, mode selection and output flop preset.
  In cascade mode run and preset come from the unit-4 bits.
  Assumes: APB master on ref_clk_in; pins and low clock are asynchronous.
*/
// How it works
// [R1] Run bit 0 stops and clears, 1 counts
// [R2] Clock code picks prescaler tap, low clock, pin
// [R3] Undivided fast clock in sleep: warm-up only
// [R4] Mode code picks timer, divider, PWM, cascade
// [R5] Software keeps settings fixed while running
// [R6] Settings accepted on the starting write
// [R7] Cascade needs unit-3 mode fixed at 011
// [R8] Cascade count source from unit-3 clock code
// [R9] Cascade run and preset from unit 4
// [R10] Unit-4 period kept fixed while running
// [R11] Unit-4 pulse width changes only in PWM
// [R12] Preset bit loads output flop on start
// [R13] Synchronous registers, pin synchronised before counting
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_ctrl
#(
  parameter int CNT_W = 8,  // Counter width
  parameter int DIV_W = 11  // Prescaler width
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic count_pin_in,
  input wire logic low_clk_in,
  output logic count_tick_out,
  output logic [CNT_W-1:0] count_out,
  output logic flop_out,
  output logic [2:0] mode_out
);

  localparam int LOW_W = 3;  // Low-clock divider width

  tcc_pkg::tcc_ctrl_s u3_ctrl_ff;  // Unit-3 control register incl. preset
  logic u4_run_ff;  // Unit-4 run bit
  logic u4_preset_ff;  // Unit-4 flop preset bit
  logic tap_sel_ff;  // Prescaler tap select
  logic sleep_ff;  // Low-speed sleep state flag
  logic [DIV_W-1:0] div_ff;  // Free-running prescaler
  logic [LOW_W-1:0] low_div_ff;  // Divider on the low clock
  logic running_ff;  // Effective run state, last cycle
  logic [31:0] prdata_ff;  // Read data register
  logic pready_ff;  // Access-phase ready
  logic tick_ff;  // Registered count tick
  logic [CNT_W-1:0] cnt_ff;  // Counter
  logic flop_ff;  // Timer output flop
  logic [2:0] mode_ff;  // Registered mode output

  logic pin_rise;  // Synced pin edge
  logic low_rise;  // Synced low clock edge
  logic [DIV_W-1:0] nxt_div;  // Next prescaler value
  logic [LOW_W-1:0] nxt_low_div;  // Next low divider value
  logic setup_wr;  // Write taken this edge
  logic setup_rd;  // Read taken this edge
  logic tick;  // One-cycle count enable
  tcc_pkg::tcc_eff_s eff;  // Effective control
  tcc_pkg::tcc_ctrl_s wr_ctrl;  // Control field view of write data

  // Pin and low clock cross in through two flops each; see [R13]
  tcc_sync_edge u_pin_sync
  (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(count_pin_in),
    .level_out(),
    .rise_out(pin_rise)
  );

  tcc_sync_edge u_low_sync
  (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(low_clk_in),
    .level_out(),
    .rise_out(low_rise)
  );

  // APB write taken at the edge where the access phase completes, read one edge earlier
  assign setup_wr = psel_in & penable_in & pready_ff & pwrite_in;
  assign setup_rd = psel_in & penable_in & ~pready_ff & ~pwrite_in;
  assign wr_ctrl = tcc_pkg::tcc_ctrl_s'(pwdata_in[7:0]);

  // Ready raised one cycle into the access phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= psel_in & penable_in & ~pready_ff;
    end
  end

  // Unit-3 control: while running only the run bit changes; see [R5]
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      u3_ctrl_ff <= tcc_pkg::tcc_ctrl_s'(tcc_pkg::U3_CTRL_RST);
    end
    else if (setup_wr && paddr_in == tcc_pkg::ADDR_U3_CTRL)
    begin
      if (!u3_ctrl_ff.run)
      begin
        // Stopped: every field loads, incl. on the starting write; see [R6]
        u3_ctrl_ff <= wr_ctrl;
      end
      else
      begin
        // Running: settings frozen, run bit still writable; see [R1]
        u3_ctrl_ff.run <= pwdata_in[tcc_pkg::U3_RUN_BIT];
      end
    end
  end

  // Unit-4 run/preset and system control bits
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      u4_run_ff <= 1'b0;
      u4_preset_ff <= 1'b0;
      tap_sel_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else if (setup_wr)
    begin
      if (paddr_in == tcc_pkg::ADDR_U4_CTRL)
      begin
        u4_run_ff <= pwdata_in[tcc_pkg::U4_RUN_BIT];
        if (!u4_run_ff)
        begin
          // Preset only taken while unit 4 is stopped
          u4_preset_ff <= pwdata_in[tcc_pkg::U4_PRESET_BIT];
        end
      end
      if (paddr_in == tcc_pkg::ADDR_SYS_CTRL)
      begin
        tap_sel_ff <= pwdata_in[tcc_pkg::SYS_TAP_BIT];
        sleep_ff <= pwdata_in[tcc_pkg::SYS_SLEEP_BIT];
      end
    end
  end

  // Effective control: cascade takes run/preset from unit 4
  always_comb
  begin
    eff.clock_select = u3_ctrl_ff.clock_select;  // see [R8]
    eff.mode_select = u3_ctrl_ff.mode_select;  // see [R4]
    if (u3_ctrl_ff.mode_select == tcc_pkg::MD_CASCADE)
    begin
      eff.run = u4_run_ff;  // see [R9]
      eff.preset = u4_preset_ff;  // see [R9]
    end
    else
    begin
      eff.run = u3_ctrl_ff.run;
      eff.preset = u3_ctrl_ff.preset;  // see [R12]
    end
  end

  // Prescalers on the fast and low clocks
  assign nxt_div = div_ff + DIV_W'(1);
  assign nxt_low_div = low_div_ff + LOW_W'(1);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      div_ff <= '0;
      low_div_ff <= '0;
    end
    else
    begin
      div_ff <= nxt_div;
      if (low_rise)
      begin
        low_div_ff <= nxt_low_div;
      end
    end
  end

  // Source selection: a tick on the carry into the chosen tap; see [R2]
  always_comb
  begin
    unique case (eff.clock_select)
      tcc_pkg::CK_SLOWEST:
        if (tap_sel_ff || sleep_ff)
          tick = low_rise && (&low_div_ff);
        else
          tick = &div_ff[tcc_pkg::TAP_11:0];
      tcc_pkg::CK_DIV7: tick = &div_ff[tcc_pkg::TAP_7:0];
      tcc_pkg::CK_DIV5: tick = &div_ff[tcc_pkg::TAP_5:0];
      tcc_pkg::CK_DIV3: tick = &div_ff[tcc_pkg::TAP_3:0];
      tcc_pkg::CK_LOW: tick = low_rise;
      tcc_pkg::CK_DIV1: tick = div_ff[tcc_pkg::TAP_1];
      // Undivided clock; in sleep usable only for warm-up, see [R3]
      tcc_pkg::CK_HIGH: tick = 1'b1;
      tcc_pkg::CK_PIN: tick = pin_rise;  // see [R13]
    endcase
  end

  // Counter: stop clears it, run counts on ticks; see [R1]
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
      running_ff <= 1'b0;
    end
    else
    begin
      running_ff <= eff.run;
      tick_ff <= eff.run & tick;
      if (!eff.run)
        cnt_ff <= '0;
      else if (tick)
        cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // Output flop follows the preset while stopped and at start; see [R12]
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      flop_ff <= 1'b0;
      mode_ff <= tcc_pkg::MD_TIMER;
    end
    else
    begin
      mode_ff <= eff.mode_select;
      if (!running_ff)
        flop_ff <= eff.preset;
    end
  end

  // Read data, registered during the access phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_ff <= '0;
    end
    else if (setup_rd)
    begin
      unique case (paddr_in)
        tcc_pkg::ADDR_U3_CTRL:
          prdata_ff <= {24'h000000, u3_ctrl_ff};
        tcc_pkg::ADDR_U4_CTRL:
          prdata_ff <= {30'h0, u4_preset_ff, u4_run_ff};
        tcc_pkg::ADDR_SYS_CTRL:
          prdata_ff <= {30'h0, sleep_ff, tap_sel_ff};
        tcc_pkg::ADDR_STATUS:
          prdata_ff <= {22'h0, flop_ff, running_ff, 8'(cnt_ff)};
        default: prdata_ff <= '0;
      endcase
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = 1'b0;
  assign count_tick_out = tick_ff;
  assign count_out = cnt_ff;
  assign flop_out = flop_ff;
  assign mode_out = mode_ff;

endmodule
`default_nettype wire

/* hdl/tcc_pkg.sv */
/*
  Shared constants and types for the cascadable 8-bit timer control block:
  register offsets, field layout of the unit-3 control register, clock
  source and mode codes, prescaler taps.
  Assumes: one 40 MHz system clock, APB register access.
*/
package tcc_pkg;

  // Register byte addresses on the APB bus
  localparam logic [7:0] ADDR_U3_CTRL = 8'h00;  // Unit-3 control
  localparam logic [7:0] ADDR_U4_CTRL = 8'h04;  // Unit-4 run and preset
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h08;  // Tap select, sleep flag
  localparam logic [7:0] ADDR_STATUS = 8'h0c;  // Running, flop, count

  // Field positions in the unit-3 control register
  localparam int U3_PRESET_BIT = 7;
  localparam int U3_CLK_LSB = 4;
  localparam int U3_RUN_BIT = 3;
  localparam int U3_MODE_LSB = 0;

  // Unit-4 control and system control bit positions
  localparam int U4_RUN_BIT = 0;
  localparam int U4_PRESET_BIT = 1;
  localparam int SYS_TAP_BIT = 0;
  localparam int SYS_SLEEP_BIT = 1;

  // Reset values
  localparam logic [7:0] U3_CTRL_RST = 8'h00;

  // Clock source codes
  localparam logic [2:0] CK_SLOWEST = 3'h0;  // fc/2^11 or fs/2^3
  localparam logic [2:0] CK_DIV7 = 3'h1;
  localparam logic [2:0] CK_DIV5 = 3'h2;
  localparam logic [2:0] CK_DIV3 = 3'h3;
  localparam logic [2:0] CK_LOW = 3'h4;
  localparam logic [2:0] CK_DIV1 = 3'h5;
  localparam logic [2:0] CK_HIGH = 3'h6;
  localparam logic [2:0] CK_PIN = 3'h7;

  // Mode codes
  localparam logic [2:0] MD_TIMER = 3'h0;
  localparam logic [2:0] MD_DIVOUT = 3'h1;
  localparam logic [2:0] MD_PWM = 3'h2;
  localparam logic [2:0] MD_CASCADE = 3'h3;

  // Prescaler taps (bit index of the free-running divider)
  localparam int TAP_11 = 10;
  localparam int TAP_7 = 6;
  localparam int TAP_5 = 4;
  localparam int TAP_3 = 2;
  localparam int TAP_1 = 0;
  localparam int LOW_TAP_3 = 2;

  // Unit-3 control register layout
  typedef struct packed {
    logic preset;  // Output flop preset, top bit
    logic [2:0] clock_select;
    logic run;
    logic [2:0] mode_select;
  } tcc_ctrl_s;

  // Effective settings handed to the counter
  typedef struct packed {
    logic run;
    logic preset;
    logic [2:0] clock_select;
    logic [2:0] mode_select;
  } tcc_eff_s;

endpackage

/* hdl/tcc_sync_edge.sv */
/*
  Two-flop synchroniser with rising-edge pulse, for the external count pin
  and the low-frequency clock input.
  Assumes: input is asynchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module tcc_sync_edge
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);

  logic meta_ff;  // First stage, read only by the second
  logic sync_ff;  // Second stage
  logic last_ff;  // Previous synced value for edge detect

  // Synchroniser chain
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Outputs from the later stages only
  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~last_ff;

endmodule
`default_nettype wire

/* test/tcc_pin_src.sv */
/* Pulse source for the external count pin.
   Assumes: runs from the bench clock; pin idles low. */
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_src
(
  input wire logic clk_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // Send n edges; hold sets high and low width
  task automatic burst(input int n, input int hold);
    repeat (n)
    begin
      @(posedge clk_in) pin_out <= 1'b1;
      repeat (hold) @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (hold) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

/* test/tcc_ctrl_assertions.sv */
/* Port checker for the timer control block.
   Assumes: bound to tcc_timer_ctrl, one clock. */
`timescale 1ns/100ps
`default_nettype none
module tcc_ctrl_assertions
#(
  parameter int CNT_W = 8,
  parameter int DIV_W = 11
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic count_pin_in,
  input wire logic low_clk_in,
  input wire logic count_tick_out,
  input wire logic [CNT_W-1:0] count_out,
  input wire logic flop_out,
  input wire logic [2:0] mode_out
);
  logic u3_wr;  // Taken write to unit-3 control
  logic run_ff;  // Run bit as software wrote it
  logic pre_ff;  // Preset bit as software wrote it
  logic [2:0] mode_wr;  // Mode field of the write data
  assign u3_wr = psel_in && penable_in && pready_out && pwrite_in &&
    (paddr_in == tcc_pkg::ADDR_U3_CTRL);
  assign mode_wr = pwdata_in[tcc_pkg::U3_MODE_LSB +: 3];
  // Mirror the written run and preset bits
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      run_ff <= 1'b0;
      pre_ff <= 1'b0;
    end
    else if (u3_wr)
    begin
      run_ff <= pwdata_in[tcc_pkg::U3_RUN_BIT];
      pre_ff <= pwdata_in[tcc_pkg::U3_PRESET_BIT];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_NO_ERR: assert property (!pslverr_out)
    else $error("slave error raised");
  AST_RDY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_RDY_WAIT: assert property (
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready late");
  AST_HI_ZERO: assert property (
    pready_out && !pwrite_in |-> prdata_out[31:10] == 22'h0)
    else $error("upper read bits set");
  AST_CNT_STEP: assert property (
    count_out != $past(count_out)
    |-> count_out == '0 || count_out == $past(count_out) + 1'b1)
    else $error("counter jumped");
  AST_STOP_CLR: assert property (
    u3_wr && !pwdata_in[tcc_pkg::U3_RUN_BIT] &&
    mode_wr != tcc_pkg::MD_CASCADE && mode_out != tcc_pkg::MD_CASCADE
    |-> ##2 count_out == '0)
    else $error("stop did not clear");
  AST_MODE_ACC: assert property (
    u3_wr && !run_ff && pwdata_in[tcc_pkg::U3_RUN_BIT]
    |-> ##2 mode_out == $past(mode_wr, 2))
    else $error("mode not taken on start");
  AST_MODE_HOLD: assert property (
    u3_wr && run_ff |-> ##2 $stable(mode_out))
    else $error("mode changed while running");
  AST_FLOP_STOP: assert property (
    u3_wr && !run_ff && !pwdata_in[tcc_pkg::U3_RUN_BIT] &&
    mode_wr != tcc_pkg::MD_CASCADE && mode_out != tcc_pkg::MD_CASCADE
    |-> ##2 flop_out == pre_ff)
    else $error("flop not preset");
  cover property (u3_wr && pwdata_in[3]);
  cover property (mode_out == 3'h3 && count_tick_out);
  cover property (count_tick_out && run_ff);
endmodule
bind tcc_timer_ctrl tcc_ctrl_assertions #(.CNT_W(CNT_W), .DIV_W(DIV_W))
  u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .count_pin_in(count_pin_in),
  .low_clk_in(low_clk_in), .count_tick_out(count_tick_out),
  .count_out(count_out), .flop_out(flop_out), .mode_out(mode_out));
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench for the timer control block.
   Assumes: design, package and pin source compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rv;
  logic rdy;
  logic [4:0] lc = 5'h00;  // Low clock divider
  logic pin;
  logic tick;
  logic [7:0] cnt;
  logic flop;
  logic [2:0] mode;
  int n_fail = 0;
  int n_compared = 0;
  int n_tick = 0;
  logic [31:0] lf = 32'hed8b;  // Random state
  always #12.5 clk = ~clk;
  // Low clock of 32 cycles; tick counter
  always @(posedge clk) lc <= lc + 5'h01;
  always @(posedge clk) n_tick <= n_tick + int'(tick === 1'b1);
  tcc_pin_src pin_src (.clk_in(clk), .pin_out(pin));
  tcc_timer_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(), .count_pin_in(pin), .low_clk_in(lc[4]),
    .count_tick_out(tick), .count_out(cnt), .flop_out(flop),
    .mode_out(mode));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // Control word: mode, run, clock code, preset
  function automatic logic [31:0] ctl(input logic [2:0] m,
    input logic [2:0] c, input logic r, input logic p);
    return {24'h0, p, c, r, m};
  endfunction
  // Clocks between ticks for a clock code
  function automatic int per(input logic [2:0] c, input logic t);
    case (c)
      3'h0: return t ? 256 : 2048;
      3'h1: return 128;
      3'h2: return 32;
      3'h3: return 8;
      3'h4: return 32;
      3'h5: return 2;
      default: return 1;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer, waits for ready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rdy !== 1'b1 && k < 16);
    rv = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    if (rdy !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // Count ticks over eight periods
  task automatic ticks(input int p, input int e);
    int t0;
    repeat (2 * p + 8) @(posedge clk);
    t0 = n_tick;
    repeat (8 * p) @(posedge clk);
    chk("ticks", 32'(e), 32'(n_tick - t0));
  endtask
  initial
  begin
    logic [2:0] c;
    logic [2:0] m;
    logic [31:0] x;
    logic p;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
    chk("reset", 32'h0, rv);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rv);
    // Every clock code, low variant of 000 last
    for (int i = 0; i < 9; i++)
    begin
      c = i[2:0];
      x = rnd();
      m = x[0] ? tcc_pkg::MD_PWM : {2'b00, x[1]};
      p = x[7];
      if (c == 3'h7)
        m = tcc_pkg::MD_TIMER;
      apb(1'b1, tcc_pkg::ADDR_SYS_CTRL, 32'(i == 8));
      apb(1'b1, tcc_pkg::ADDR_U3_CTRL, ctl(m, c, 1'b0, p));
      apb(1'b0, tcc_pkg::ADDR_U3_CTRL, 32'h0);
      chk("u3 read", ctl(m, c, 1'b0, p), rv);
      apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
      chk("preset", {22'h0, p, 9'h0}, rv);
      apb(1'b1, tcc_pkg::ADDR_U3_CTRL, ctl(m, c, 1'b1, p));
      @(posedge clk);
      chk("mode", 32'(m), 32'(mode));
      apb(1'b1, tcc_pkg::ADDR_U3_CTRL, ctl(m ^ 3'h1, ~c, 1'b1, ~p));
      @(posedge clk);
      chk("held", 32'(m), 32'(mode));
      chk("flop", 32'(p), 32'(flop));
      if (c == 3'h7)
      begin
        pin_src.burst(3 + int'(x[5:2]), x[6] ? 2 : 6);
        repeat (8) @(posedge clk);
        apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
        chk("pin", 32'(3 + x[5:2]), rv & 32'hff);
      end
      else
        ticks(per(c, i == 8), 8);
      apb(1'b1, tcc_pkg::ADDR_U3_CTRL, ctl(m, c, 1'b0, p));
      apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
      chk("stop", 32'h0, rv & 32'h1ff);
    end
    // Cascade: unit-3 run ignored, unit 4 runs it; fast code at full
    // speed only; unit-4 period and pulse registers never rewritten
    apb(1'b1, tcc_pkg::ADDR_U3_CTRL,
      ctl(tcc_pkg::MD_CASCADE, 3'h6, 1'b1, 1'b0));
    ticks(1, 0);
    apb(1'b1, tcc_pkg::ADDR_U4_CTRL, 32'h3);
    ticks(1, 8);
    apb(1'b1, tcc_pkg::ADDR_U4_CTRL, 32'h0);
    apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
    chk("u4 stop", 32'h200, rv & 32'h3ff);
    apb(1'b1, tcc_pkg::ADDR_U4_CTRL, 32'h0);
    apb(1'b0, tcc_pkg::ADDR_STATUS, 32'h0);
    chk("u4 preset", 32'h0, rv & 32'h3ff);
    report_and_stop();
  end
endmodule
`default_nettype wire
